// >>> slf_consts.vh
// Purpose: constants for the synthesizer loop-filter configuration register bank
// Assumes: byte-wide registers on an 8-bit address space
// Notes: offsets are byte addresses on the plain register port
`ifndef SLF_CONSTS_VH
`define SLF_CONSTS_VH

// bus widths
`define SLF_ADDR_W 8
`define SLF_DATA_W 8

// register offsets
`define SLF_OFS_SERIES_RES 8'h43
`define SLF_OFS_MAIN_CAP 8'h44
`define SLF_OFS_POLE_RES 8'h45
`define SLF_OFS_POLE_CAP 8'h46
`define SLF_OFS_SYNTH2_CTRL_LOW 8'h47

// field positions
`define SLF_SERIES_RES_MSB 5
`define SLF_SERIES_RES_LSB 0
`define SLF_MAIN_CAP_MSB 2
`define SLF_MAIN_CAP_LSB 0
`define SLF_POLE_RES_MSB 6
`define SLF_POLE_RES_LSB 1
`define SLF_FILTER_TYPE_BIT 0
`define SLF_POLE_CAP_MSB 2
`define SLF_POLE_CAP_LSB 0
`define SLF_POST_DIV_MSB 4
`define SLF_POST_DIV_LSB 2

// reset values of the fields
`define SLF_RST_SERIES_RES 6'h24
`define SLF_RST_MAIN_CAP 3'h0
`define SLF_RST_POLE_RES 6'h00
`define SLF_RST_FILTER_TYPE 1'h0
`define SLF_RST_POLE_CAP 3'h0
`define SLF_RST_POST_DIV 3'h7

// reset values of the decoded settings, the decodes of the reset codes
`define SLF_RST_SERIES_OHMS 12'h000
`define SLF_RST_SERIES_LISTED 1'h0
`define SLF_RST_MAIN_CAP_PF 9'h005
`define SLF_RST_POLE_OHMS 12'h012
`define SLF_RST_POLE_LISTED 1'h1
`define SLF_RST_POLE_CAP_PF 6'h00
`define SLF_RST_POST_DIV_RATIO 4'h8

// filter type encodings
`define SLF_FILTER_INTEGER 1'h0
`define SLF_FILTER_FRACTIONAL 1'h1

// capacitance arithmetic, in pF
`define SLF_MAIN_CAP_BASE_PF 9'h005
`define SLF_MAIN_CAP_STEP_PF 9'h032
`define SLF_POLE_CAP_STEP_PF 6'h05

// post divider: code 0 divides by 2, otherwise code plus one
`define SLF_POST_DIV_ZERO_RATIO 4'h2
`define SLF_POST_DIV_OFFSET 4'h1

// series resistor listed codes and ohms
`define SLF_SR_CODE_A 6'h01
`define SLF_SR_CODE_B 6'h02
`define SLF_SR_CODE_C 6'h04
`define SLF_SR_CODE_D 6'h08
`define SLF_SR_CODE_E 6'h20
`define SLF_SR_CODE_F 6'h30
`define SLF_SR_OHMS_A 12'h0ec
`define SLF_SR_OHMS_B 12'h150
`define SLF_SR_OHMS_C 12'h218
`define SLF_SR_OHMS_D 12'h2df
`define SLF_SR_OHMS_E 12'h664
`define SLF_SR_OHMS_F 12'h972

// pole resistor listed codes and ohms
`define SLF_PR_CODE_A 6'h00
`define SLF_PR_CODE_B 6'h02
`define SLF_PR_CODE_C 6'h04
`define SLF_PR_CODE_D 6'h08
`define SLF_PR_CODE_E 6'h10
`define SLF_PR_CODE_F 6'h20
`define SLF_PR_CODE_G 6'h40
`define SLF_PR_OHMS_A 12'h012
`define SLF_PR_OHMS_B 12'h13e
`define SLF_PR_OHMS_C 12'h206
`define SLF_PR_OHMS_D 12'h2cd
`define SLF_PR_OHMS_E 12'h356
`define SLF_PR_OHMS_F 12'h676
`define SLF_PR_OHMS_G 12'hcb6

`endif

// >>> slf_regs.v
// Purpose: loop-filter configuration registers of the first synthesizer and the
//          post-divider field of the second synthesizer, with decoded settings
// Assumes: one clock; software drives a plain address / strobe register port
// Notes: decoded outputs change on the same edge as the register they follow
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "slf_consts.vh"

module slf_regs (
  // clock and reset
  input wire mclk_i,
  input wire reset_i,
  // register port
  input wire [`SLF_ADDR_W-1:0] addr_i,
  input wire [`SLF_DATA_W-1:0] wr_data_i,
  input wire wr_en_i,
  input wire rd_en_i,
  output reg [`SLF_DATA_W-1:0] rd_data_o,
  output reg rd_valid_o,
  // first synthesizer series resistor
  output reg [5:0] first_synth_series_resistor_code_o,
  output reg [11:0] first_synth_series_resistor_ohms_o,
  output reg first_synth_series_resistor_listed_o,
  // first synthesizer main capacitor
  output reg [2:0] first_synth_main_capacitor_code_o,
  output reg [8:0] first_synth_main_capacitor_pf_o,
  // first synthesizer pole resistor and filter type
  output reg [5:0] first_synth_pole_resistor_code_o,
  output reg [11:0] first_synth_pole_resistor_ohms_o,
  output reg first_synth_pole_resistor_listed_o,
  output reg first_synth_filter_type_select_o,
  // first synthesizer pole capacitor
  output reg [2:0] first_synth_pole_capacitor_code_o,
  output reg [5:0] first_synth_pole_capacitor_pf_o,
  // second synthesizer post divider
  output reg [2:0] second_synth_post_divider_select_o,
  output reg [3:0] second_synth_post_divider_ratio_o
);

  // register state
  reg [5:0] series_res_q;
  reg [5:0] series_res_d;
  reg [2:0] main_cap_q;
  reg [2:0] main_cap_d;
  reg [5:0] pole_res_q;
  reg [5:0] pole_res_d;
  reg filter_type_q;
  reg filter_type_d;
  reg [2:0] pole_cap_q;
  reg [2:0] pole_cap_d;
  reg [2:0] post_div_q;
  reg [2:0] post_div_d;
  reg [`SLF_DATA_W-1:0] rd_data_d;

  // write decode
  wire wr_series_res;
  wire wr_main_cap;
  wire wr_pole_res;
  wire wr_pole_cap;
  wire wr_post_div;

  // true when a write strobe targets the given offset
  function wr_hit;
    input en;
    input [`SLF_ADDR_W-1:0] addr;
    input [`SLF_ADDR_W-1:0] ofs;
    begin
      wr_hit = en & (addr == ofs);
    end
  endfunction

  // listed series resistor values; unlisted codes still drive the filter
  function [12:0] series_ohms;
    input [5:0] code;
    begin
      case (code)
        `SLF_SR_CODE_A: series_ohms = {1'b1, `SLF_SR_OHMS_A};
        `SLF_SR_CODE_B: series_ohms = {1'b1, `SLF_SR_OHMS_B};
        `SLF_SR_CODE_C: series_ohms = {1'b1, `SLF_SR_OHMS_C};
        `SLF_SR_CODE_D: series_ohms = {1'b1, `SLF_SR_OHMS_D};
        `SLF_SR_CODE_E: series_ohms = {1'b1, `SLF_SR_OHMS_E};
        `SLF_SR_CODE_F: series_ohms = {1'b1, `SLF_SR_OHMS_F};
        default: series_ohms = 13'h0000;
      endcase
    end
  endfunction

  // listed pole resistor values; the code field is six bits so 64 is unreachable
  // through the field alone, the seventh entry covers a wider code
  function [12:0] pole_ohms;
    input [6:0] code;
    begin
      case (code)
        {1'b0, `SLF_PR_CODE_A}: pole_ohms = {1'b1, `SLF_PR_OHMS_A};
        {1'b0, `SLF_PR_CODE_B}: pole_ohms = {1'b1, `SLF_PR_OHMS_B};
        {1'b0, `SLF_PR_CODE_C}: pole_ohms = {1'b1, `SLF_PR_OHMS_C};
        {1'b0, `SLF_PR_CODE_D}: pole_ohms = {1'b1, `SLF_PR_OHMS_D};
        {1'b0, `SLF_PR_CODE_E}: pole_ohms = {1'b1, `SLF_PR_OHMS_E};
        {1'b0, `SLF_PR_CODE_F}: pole_ohms = {1'b1, `SLF_PR_OHMS_F};
        {1'b1, `SLF_PR_CODE_A}: pole_ohms = {1'b1, `SLF_PR_OHMS_G};
        default: pole_ohms = 13'h0000;
      endcase
    end
  endfunction

  // main capacitor in pF, 5 + 50 * code
  function [8:0] main_cap_pf;
    input [2:0] code;
    begin
      main_cap_pf = `SLF_MAIN_CAP_BASE_PF + `SLF_MAIN_CAP_STEP_PF * {6'h00, code};
    end
  endfunction

  // pole capacitor in pF, 5 * code
  function [5:0] pole_cap_pf;
    input [2:0] code;
    begin
      pole_cap_pf = `SLF_POLE_CAP_STEP_PF * {3'h0, code};
    end
  endfunction

  // post divide ratio: code 0 gives 2, other codes give code + 1
  function [3:0] post_div_ratio;
    input [2:0] code;
    begin
      if (code == 3'h0)
        post_div_ratio = `SLF_POST_DIV_ZERO_RATIO;
      else
        post_div_ratio = {1'b0, code} + `SLF_POST_DIV_OFFSET;
    end
  endfunction

  // the full address is compared: a partial decode would alias neighbouring
  // registers onto this bank and let their writes land here
  assign wr_series_res = wr_hit(wr_en_i, addr_i, `SLF_OFS_SERIES_RES);
  assign wr_main_cap = wr_hit(wr_en_i, addr_i, `SLF_OFS_MAIN_CAP);
  assign wr_pole_res = wr_hit(wr_en_i, addr_i, `SLF_OFS_POLE_RES);
  assign wr_pole_cap = wr_hit(wr_en_i, addr_i, `SLF_OFS_POLE_CAP);
  assign wr_post_div = wr_hit(wr_en_i, addr_i, `SLF_OFS_SYNTH2_CTRL_LOW);

  // next values; only the defined field bits are taken from a write
  always @*
  begin
    series_res_d = series_res_q;
    main_cap_d = main_cap_q;
    pole_res_d = pole_res_q;
    filter_type_d = filter_type_q;
    pole_cap_d = pole_cap_q;
    post_div_d = post_div_q;
    if (wr_series_res)
      series_res_d = wr_data_i[`SLF_SERIES_RES_MSB:`SLF_SERIES_RES_LSB];
    if (wr_main_cap)
      main_cap_d = wr_data_i[`SLF_MAIN_CAP_MSB:`SLF_MAIN_CAP_LSB];
    if (wr_pole_res)
    begin
      pole_res_d = wr_data_i[`SLF_POLE_RES_MSB:`SLF_POLE_RES_LSB];
      filter_type_d = wr_data_i[`SLF_FILTER_TYPE_BIT];
    end
    if (wr_pole_cap)
      pole_cap_d = wr_data_i[`SLF_POLE_CAP_MSB:`SLF_POLE_CAP_LSB];
    // bits 1..0 of this byte belong to another block and are not held here
    if (wr_post_div)
      post_div_d = wr_data_i[`SLF_POST_DIV_MSB:`SLF_POST_DIV_LSB];
  end

  // read mux; unmapped offsets and reserved bits answer zero
  always @*
  begin
    rd_data_d = 8'h00;
    if (rd_en_i)
    begin
      case (addr_i)
        `SLF_OFS_SERIES_RES: rd_data_d = {2'h0, series_res_q};
        `SLF_OFS_MAIN_CAP: rd_data_d = {5'h00, main_cap_q};
        `SLF_OFS_POLE_RES: rd_data_d = {1'b0, pole_res_q, filter_type_q};
        `SLF_OFS_POLE_CAP: rd_data_d = {5'h00, pole_cap_q};
        `SLF_OFS_SYNTH2_CTRL_LOW: rd_data_d = {3'h0, post_div_q, 2'h0};
        default: rd_data_d = 8'h00;
      endcase
    end
  end

  // one flop group per register: reserved bits have no storage at all, so a
  // write to them cannot change anything behind this bank
  // series resistor code
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      series_res_q <= `SLF_RST_SERIES_RES;
    else
      series_res_q <= series_res_d;
  end

  // main capacitor code
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      main_cap_q <= `SLF_RST_MAIN_CAP;
    else
      main_cap_q <= main_cap_d;
  end

  // pole resistor code and filter type share one byte
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pole_res_q <= `SLF_RST_POLE_RES;
      filter_type_q <= `SLF_RST_FILTER_TYPE;
    end
    else
    begin
      pole_res_q <= pole_res_d;
      filter_type_q <= filter_type_d;
    end
  end

  // pole capacitor code
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      pole_cap_q <= `SLF_RST_POLE_CAP;
    else
      pole_cap_q <= pole_cap_d;
  end

  // post-divider code; the low two bits of its byte live in another block
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      post_div_q <= `SLF_RST_POST_DIV;
    else
      post_div_q <= post_div_d;
  end

  // read answer stands for exactly the cycle after the strobe
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
    end
    else
    begin
      rd_data_o <= rd_data_d;
      rd_valid_o <= rd_en_i;
    end
  end

  // decoded settings are computed from next values so they track the registers
  // on the same edge; reset values are those decodes of the reset codes
  // series decode: unlisted codes still drive the filter but report zero ohms
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      first_synth_series_resistor_code_o <= `SLF_RST_SERIES_RES;
      first_synth_series_resistor_ohms_o <= `SLF_RST_SERIES_OHMS;
      first_synth_series_resistor_listed_o <= `SLF_RST_SERIES_LISTED;
    end
    else
    begin
      first_synth_series_resistor_code_o <= series_res_d;
      {first_synth_series_resistor_listed_o, first_synth_series_resistor_ohms_o} <=
        series_ohms(series_res_d);
    end
  end

  // main capacitor decode; nine bits hold the largest value, 355 pF
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      first_synth_main_capacitor_code_o <= `SLF_RST_MAIN_CAP;
      first_synth_main_capacitor_pf_o <= `SLF_RST_MAIN_CAP_PF;
    end
    else
    begin
      first_synth_main_capacitor_code_o <= main_cap_d;
      first_synth_main_capacitor_pf_o <= main_cap_pf(main_cap_d);
    end
  end

  // pole decode: the 3254 ohm entry needs a seventh code bit that the field
  // does not have, so it is never reported as listed
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      first_synth_pole_resistor_code_o <= `SLF_RST_POLE_RES;
      first_synth_pole_resistor_ohms_o <= `SLF_RST_POLE_OHMS;
      first_synth_pole_resistor_listed_o <= `SLF_RST_POLE_LISTED;
      first_synth_filter_type_select_o <= `SLF_FILTER_INTEGER;
    end
    else
    begin
      first_synth_pole_resistor_code_o <= pole_res_d;
      {first_synth_pole_resistor_listed_o, first_synth_pole_resistor_ohms_o} <=
        pole_ohms({1'b0, pole_res_d});
      first_synth_filter_type_select_o <= filter_type_d;
    end
  end

  // pole capacitor decode
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      first_synth_pole_capacitor_code_o <= `SLF_RST_POLE_CAP;
      first_synth_pole_capacitor_pf_o <= `SLF_RST_POLE_CAP_PF;
    end
    else
    begin
      first_synth_pole_capacitor_code_o <= pole_cap_d;
      first_synth_pole_capacitor_pf_o <= pole_cap_pf(pole_cap_d);
    end
  end

  // select and ratio leave the bank on one edge, so no consumer sees a
  // new ratio beside an old select
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      second_synth_post_divider_select_o <= `SLF_RST_POST_DIV;
      second_synth_post_divider_ratio_o <= `SLF_RST_POST_DIV_RATIO;
    end
    else
    begin
      second_synth_post_divider_select_o <= post_div_d;
      second_synth_post_divider_ratio_o <= post_div_ratio(post_div_d);
    end
  end

endmodule // slf_regs

// >>> slf_regs_props.sv
// Purpose: port assertions for the loop-filter register bank
// Assumes: one clock, asynchronous active-high reset
// Notes: read data are judged after a read strobe only at offset 8'h47, and must be zero after every cycle with no strobe
`timescale 1ns/1ps
module slf_regs_props (
  // clock, reset and register port
  input wire mclk_i,
  input wire reset_i,
  input wire [7:0] addr_i,
  input wire [7:0] wr_data_i,
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [7:0] rd_data_o,
  input wire rd_valid_o,
  // decoded settings
  input wire [5:0] first_synth_series_resistor_code_o,
  input wire [8:0] first_synth_main_capacitor_pf_o,
  input wire [5:0] first_synth_pole_resistor_code_o,
  input wire first_synth_filter_type_select_o,
  input wire [5:0] first_synth_pole_capacitor_pf_o,
  input wire [2:0] second_synth_post_divider_select_o,
  input wire [3:0] second_synth_post_divider_ratio_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  property p_rd_lat;
    rd_en_i |=> rd_valid_o;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer missing");
  property p_rd_idle;
    !rd_en_i |=> rd_valid_o == 1'b0 && rd_data_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
  property p_series;
    wr_en_i && addr_i == 8'h43 |=> first_synth_series_resistor_code_o == $past(wr_data_i[5:0]);
  endproperty
  a_series: assert property (p_series) else $error("series code not written");
  property p_main_pf;
    wr_en_i && addr_i == 8'h44 |=> first_synth_main_capacitor_pf_o == 9'h005 + 9'h032 * $past(wr_data_i[2:0]);
  endproperty
  a_main_pf: assert property (p_main_pf) else $error("main capacitance wrong");
  property p_pole;
    wr_en_i && addr_i == 8'h45 |=> first_synth_pole_resistor_code_o == $past(wr_data_i[6:1])
      && first_synth_filter_type_select_o == $past(wr_data_i[0]);
  endproperty
  a_pole: assert property (p_pole) else $error("pole code or filter type wrong");
  property p_pole_pf;
    wr_en_i && addr_i == 8'h46 |=> first_synth_pole_capacitor_pf_o == 6'h05 * $past(wr_data_i[2:0]);
  endproperty
  a_pole_pf: assert property (p_pole_pf) else $error("pole capacitance wrong");
  property p_post_div;
    wr_en_i && addr_i == 8'h47 |=> second_synth_post_divider_ratio_o ==
      (($past(wr_data_i[4:2]) == 3'h0) ? 4'h2 : {1'b0, $past(wr_data_i[4:2])} + 4'h1);
  endproperty
  a_post_div: assert property (p_post_div) else $error("post divider ratio wrong");
  property p_rsv_rd;
    rd_en_i && addr_i == 8'h47 |=> rd_data_o == {3'h0, second_synth_post_divider_select_o, 2'h0};
  endproperty
  a_rsv_rd: assert property (p_rsv_rd) else $error("reserved bits not zero");
  property p_pole_hold;
    !(wr_en_i && addr_i == 8'h45) |=> $stable(first_synth_pole_resistor_code_o)
      && $stable(first_synth_filter_type_select_o);
  endproperty
  a_pole_hold: assert property (p_pole_hold) else $error("pole field moved without write");
endmodule // slf_regs_props

bind slf_regs slf_regs_props u_props (.*);

// >>> slf_regs_tb.sv
// Purpose: self-checking bench for the loop-filter register bank
// Assumes: 50 MHz clock, reset held 8 cycles, plain strobe register port
// Notes: unlisted resistor codes are expected to report zero ohms
`timescale 1ns/1ps
module slf_regs_tb;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  wire [7:0] rd_data_o;
  wire rd_valid_o;
  wire [5:0] first_synth_series_resistor_code_o, first_synth_pole_resistor_code_o, first_synth_pole_capacitor_pf_o;
  wire [11:0] first_synth_series_resistor_ohms_o, first_synth_pole_resistor_ohms_o;
  wire first_synth_series_resistor_listed_o, first_synth_pole_resistor_listed_o, first_synth_filter_type_select_o;
  wire [2:0] first_synth_main_capacitor_code_o, first_synth_pole_capacitor_code_o, second_synth_post_divider_select_o;
  wire [8:0] first_synth_main_capacitor_pf_o;
  wire [3:0] second_synth_post_divider_ratio_o;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  slf_regs dut_u (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .addr_i(addr_i),
    .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i),
    .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o),
    .first_synth_series_resistor_code_o(first_synth_series_resistor_code_o),
    .first_synth_series_resistor_ohms_o(first_synth_series_resistor_ohms_o),
    .first_synth_series_resistor_listed_o(first_synth_series_resistor_listed_o),
    .first_synth_main_capacitor_code_o(first_synth_main_capacitor_code_o),
    .first_synth_main_capacitor_pf_o(first_synth_main_capacitor_pf_o),
    .first_synth_pole_resistor_code_o(first_synth_pole_resistor_code_o),
    .first_synth_pole_resistor_ohms_o(first_synth_pole_resistor_ohms_o),
    .first_synth_pole_resistor_listed_o(first_synth_pole_resistor_listed_o),
    .first_synth_filter_type_select_o(first_synth_filter_type_select_o),
    .first_synth_pole_capacitor_code_o(first_synth_pole_capacitor_code_o),
    .first_synth_pole_capacitor_pf_o(first_synth_pole_capacitor_pf_o),
    .second_synth_post_divider_select_o(second_synth_post_divider_select_o),
    .second_synth_post_divider_ratio_o(second_synth_post_divider_ratio_o)
  );
  always #10 mclk_i = ~mclk_i;
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // generous ceiling: the whole sequence needs fewer than two hundred cycles
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_en_i <= w;
    rd_en_i <= r;
    addr_i <= a;
    wr_data_i <= d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
    op(1'b0, 1'b0, a, d);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    op(1'b0, 1'b1, a, 8'h00);
    op(1'b0, 1'b0, a, 8'h00);
    #1;
    chk({4'h0, rd_data_o}, {4'h0, e});
    chk({11'h0, rd_valid_o}, 12'h001);
  endtask
  task automatic t_reset();
    rd(8'h43, 8'h24);
    rd(8'h44, 8'h00);
    rd(8'h45, 8'h00);
    rd(8'h46, 8'h00);
    rd(8'h47, 8'h1c);
    chk({8'h0, second_synth_post_divider_ratio_o}, 12'h008);
    chk({3'h0, first_synth_main_capacitor_pf_o}, 12'h005);
    chk(first_synth_series_resistor_ohms_o, 12'h000);
    chk(first_synth_pole_resistor_ohms_o, 12'h012);
    chk({11'h0, first_synth_pole_resistor_listed_o}, 12'h001);
    $display("reset values test done");
  endtask
  task automatic t_series();
    logic [5:0] c[7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h20, 6'h30, 6'h03};
    logic [11:0] o[7] = '{12'h0ec, 12'h150, 12'h218, 12'h2df, 12'h664, 12'h972, 12'h000};
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h43, {2'b11, c[i]});
      chk(first_synth_series_resistor_ohms_o, o[i]);
      chk({11'h0, first_synth_series_resistor_listed_o}, {11'h0, i < 6});
      chk({6'h0, first_synth_series_resistor_code_o}, {6'h0, c[i]});
      rd(8'h43, {2'b00, c[i]});
    end
    $display("series resistor test done");
  endtask
  task automatic t_pole();
    logic [5:0] c[7] = '{6'h00, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h3f};
    logic [11:0] o[7] = '{12'h012, 12'h13e, 12'h206, 12'h2cd, 12'h356, 12'h676, 12'h000};
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h45, {1'b1, c[i], i[0]});
      chk(first_synth_pole_resistor_ohms_o, o[i]);
      chk({11'h0, first_synth_filter_type_select_o}, {11'h0, i[0]});
      chk({11'h0, first_synth_pole_resistor_listed_o}, {11'h0, i < 6});
      chk({6'h0, first_synth_pole_resistor_code_o}, {6'h0, c[i]});
      rd(8'h45, {1'b0, c[i], i[0]});
    end
    $display("pole resistor test done");
  endtask
  task automatic t_caps();
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h44, 8'hf8 | i[7:0]);
      chk({3'h0, first_synth_main_capacitor_pf_o}, 12'h005 + 12'h032 * i[11:0]);
      chk({9'h0, first_synth_main_capacitor_code_o}, i[11:0]);
      wr(8'h46, 8'hf8 | i[7:0]);
      chk({6'h0, first_synth_pole_capacitor_pf_o}, 12'h005 * i[11:0]);
      chk({9'h0, first_synth_pole_capacitor_code_o}, i[11:0]);
      rd(8'h44, i[7:0]);
      rd(8'h46, i[7:0]);
    end
    $display("capacitor test done");
  endtask
  task automatic t_post_div();
    for (int i = 0; i < 8; i++)
    begin
      // write then read with no gap: the read must see the new value
      op(1'b1, 1'b0, 8'h47, {3'b111, i[2:0], 2'b11});
      op(1'b0, 1'b1, 8'h47, 8'h00);
      op(1'b0, 1'b0, 8'h47, 8'h00);
      #1;
      chk({4'h0, rd_data_o}, {7'h0, i[2:0], 2'b00});
      chk({8'h0, second_synth_post_divider_ratio_o}, (i == 0) ? 12'h002 : i[11:0] + 12'h001);
      chk({9'h0, second_synth_post_divider_select_o}, i[11:0]);
    end
    $display("post divider test done");
  endtask
  task automatic t_unmapped();
    wr(8'h48, 8'hff);
    wr(8'h42, 8'hff);
    rd(8'h48, 8'h00);
    rd(8'h43, 8'h03);
    rd(8'h45, 8'h7e);
    $display("unmapped access test done");
  endtask
  initial
  begin
    repeat (8) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_reset();
    t_series();
    t_pole();
    t_caps();
    t_post_div();
    t_unmapped();
    // move the post divider off its default so the reset below must restore it
    wr(8'h47, 8'h00);
    // second reset in mid-run must restore every default
    @(posedge mclk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_reset();
    test_done();
  end
endmodule // slf_regs_tb
